//--- hw/tx_list_pkg.sv
// constants for the transmit list fetch engine
// assumes a 32-bit byte-addressed host memory port with byte enables
package tx_list_pkg;
  // list layout, byte offsets
  localparam logic [31:0] LINK_OFS     = 32'h0000_0000;
  localparam logic [31:0] STAT_OFS     = 32'h0000_0004;
  localparam logic [31:0] FRAG_OFS     = 32'h0000_0008;
  localparam logic [31:0] WORD_STEP    = 32'h0000_0004;
  localparam int          LINK_IGNORE  = 3;
  localparam int          MAX_FRAG     = 10;
  localparam int          DESC_WORDS   = 22;
  localparam logic [4:0]  DESC_LAST    = 5'h15;
  // fields of the status word and of a fragment count
  localparam int          FRM_CMP_BIT  = 14;
  localparam int          EOC_BIT      = 11;
  localparam int          PASS_FCS_BIT = 9;
  localparam int          PRIO_MSB     = 2;
  localparam int          FRAG_LAST    = 31;
  localparam int          SIZE_LSB     = 16;
  // byte enables for a write of the status half-word only
  localparam logic [3:0]  STAT_BE      = 4'h3;
  // network protocol types that carry a priority request
  localparam logic [1:0]  PROTO_PRIO_A = 2'h2;
  localparam logic [1:0]  PROTO_PRIO_B = 2'h3;
  // byte stream and FIFO
  localparam int          BYTE_W       = 8;
  localparam int          STREAM_W     = 13;
  localparam int          FIFO_DEPTH   = 8;
  localparam logic [7:0]  EOF_CNT_MAX  = 8'hff;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_DESC  = 3'b001,
    ST_CHECK = 3'b010,
    ST_FRAG  = 3'b011,
    ST_RDREQ = 3'b100,
    ST_DREAD = 3'b101,
    ST_UNPK  = 3'b110,
    ST_STAT  = 3'b111
  } fetch_state_t;
endpackage : tx_list_pkg

//--- hw/byte_stream_if.sv
// valid/ready byte stream between the unpacker and the FIFO
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface byte_stream_if #(parameter int WIDTH = 13);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

//--- hw/word_unpacker.sv
// splits one fetched word into bytes, from a start lane, one per cycle
// assumes the loader waits for busy_o low before the next load
`timescale 1ns/1ns
module word_unpacker (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // word to unpack
  input  wire logic        load_i,
  input  wire logic [31:0] word_i,
  input  wire logic [1:0]  lane_i,
  input  wire logic [2:0]  count_i,
  input  wire logic        last_i,
  input  wire logic [3:0]  meta_i,
  output logic             busy_o,
  // byte stream out
  byte_stream_if.src       out
);
  logic [31:0] word;
  logic [1:0]  lane;
  logic [2:0]  left;
  logic        last;
  logic [3:0]  meta;
  logic        take;

  assign take = out.valid && out.ready;
  assign busy_o = (left != 3'h0);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      left <= 3'h0;
      lane <= 2'h0;
    end else if (load_i) begin
      left <= count_i;
      lane <= lane_i;
    end else if (take) begin
      left <= left - 3'h1;
      lane <= lane + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      word <= 32'h0000_0000;
      last <= 1'b0;
      meta <= 4'h0;
    end else if (load_i) begin
      word <= word_i;
      last <= last_i;
      meta <= meta_i;
    end
  end

  // {priority, pass fcs, frame end, byte}
  assign out.valid = busy_o;
  assign out.data  = {meta, last && (left == 3'h1),
                      word[{lane, 3'h0} +: tx_list_pkg::BYTE_W]};
endmodule : word_unpacker

//--- hw/tx_fifo.sv
// shift-register FIFO; head entry and flags are flip-flops
// assumes the consumer may stall at will
`timescale 1ns/1ns
module tx_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             reset_i,
  // fill side
  byte_stream_if.snk            in,
  // drain side
  output logic [WIDTH-1:0]      out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [DEPTH-1:0] vld;
  logic             pop;
  logic             push;

  assign pop         = vld[0] && out_ready_i;
  assign push        = in.valid && in.ready;
  assign in.ready    = !vld[DEPTH-1];
  assign out_data_o  = mem[0];
  assign out_valid_o = vld[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_slot
      logic below;
      logic here;
      logic above;
      if (i == 0) begin : g_lo
        assign below = 1'b1;
      end else begin : g_mid
        assign below = vld[i-1];
      end
      if (i == DEPTH - 1) begin : g_hi
        assign above = 1'b0;
      end else begin : g_top
        assign above = vld[i+1];
      end
      assign here = vld[i];
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          vld[i] <= 1'b0;
          mem[i] <= '0;
        end else if (pop) begin
          if (push && here && !above) begin
            mem[i] <= in.data;
          end else if (above) begin
            mem[i] <= mem[i+1 < DEPTH ? i+1 : i];
          end
          vld[i] <= above || (push && here);
        end else if (push && below && !here) begin
          mem[i] <= in.data;
          vld[i] <= 1'b1;
        end
      end
    end
  endgenerate
endmodule : tx_fifo

//--- hw/tx_list_fetch_engine.sv
// transmit list fetch engine: walks chained transmit lists in host
// memory, gathers fragments into the FIFO, writes back status
// assumes a memory port where a request stands until acknowledged and
// read data is valid in the acknowledge cycle
`timescale 1ns/1ns
module tx_list_fetch_engine (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // channel control
  input  wire logic        start_i,
  input  wire logic [31:0] list_addr_i,
  input  wire logic [1:0]  net_protocol_i,
  output logic             channel_active_o,
  output logic             adapter_check_o,
  // events
  input  wire logic        eof_ack_i,
  input  wire logic        eoc_ack_i,
  output logic             eof_event_o,
  output logic             eoc_event_o,
  // host memory port
  output logic             mem_req_o,
  output logic             mem_we_o,
  output logic [31:0]      mem_addr_o,
  output logic [31:0]      mem_wdata_o,
  output logic [3:0]       mem_be_o,
  input  wire logic        mem_ack_i,
  input  wire logic [31:0] mem_rdata_i,
  // gathered frame bytes
  output logic [7:0]       tx_data_o,
  output logic             tx_last_o,
  output logic             pass_fcs_o,
  output logic [2:0]       tx_prio_o,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i
);
  tx_list_pkg::fetch_state_t state;

  logic [31:0] desc [0:tx_list_pkg::DESC_WORDS-1];
  logic [4:0]  widx;
  logic [31:0] list_base;
  logic [3:0]  frag;
  logic [31:0] cur_addr;
  logic [30:0] rem;
  logic        ld;
  logic        busy;
  logic        eoc_flag;
  logic [7:0]  eof_cnt;

  // derived from the stored list
  logic [15:0] req_stat;
  logic [15:0] frame_size;
  logic [34:0] frag_sum;
  logic [3:0]  nfrag;
  logic [3:0]  last_nz;
  logic [1:0]  lane;
  logic [2:0]  avail;
  logic [2:0]  nbytes;
  logic        is_last_word;
  logic [3:0]  meta;
  logic        proto_prio;
  logic [tx_list_pkg::STREAM_W-1:0] fifo_out;
  logic        eof_inc;
  logic        eof_dec;
  logic [31:0] mem_rdata_q;
  logic [1:0]  lane_q;
  logic [2:0]  count_q;
  logic        last_q;

  byte_stream_if #(.WIDTH(tx_list_pkg::STREAM_W)) bytes_if ();

  function automatic logic [31:0] frag_count(input logic [31:0] w);
    frag_count = {1'b0, w[30:0]};
  endfunction : frag_count

  assign req_stat   = desc[1][15:0];
  assign frame_size = desc[1][31:tx_list_pkg::SIZE_LSB];

  always_comb begin
    logic stop;
    stop     = 1'b0;
    frag_sum = 35'h0;
    nfrag    = 4'h0;
    last_nz  = 4'h0;
    for (int k = 0; k < tx_list_pkg::MAX_FRAG; k++) begin
      if (!stop) begin
        frag_sum = frag_sum + {3'h0, frag_count(desc[2 + 2*k])};
        nfrag    = 4'(k + 1);
        if (frag_count(desc[2 + 2*k]) != 32'h0) begin
          last_nz = 4'(k);
        end
        stop = desc[2 + 2*k][tx_list_pkg::FRAG_LAST];
      end
    end
  end

  // byte-granular lane and length per word
  assign lane   = cur_addr[1:0];
  assign avail  = 3'h4 - {1'b0, lane};
  assign nbytes = (rem < {28'h0, avail}) ? rem[2:0] : avail;
  assign is_last_word = (frag == last_nz) && (rem == {28'h0, nbytes});

  // priority only for protocol types 2 and 3
  assign proto_prio = (net_protocol_i == tx_list_pkg::PROTO_PRIO_A) ||
                      (net_protocol_i == tx_list_pkg::PROTO_PRIO_B);
  // supplied-FCS flag travels with every byte
  assign meta = {proto_prio ? req_stat[tx_list_pkg::PRIO_MSB:0] : 3'h0,
                 req_stat[tx_list_pkg::PASS_FCS_BIT]};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state            <= tx_list_pkg::ST_IDLE;
      widx             <= 5'h0;
      list_base        <= 32'h0000_0000;
      frag             <= 4'h0;
      cur_addr         <= 32'h0000_0000;
      rem              <= 31'h0;
      ld               <= 1'b0;
      channel_active_o <= 1'b0;
      adapter_check_o  <= 1'b0;
      mem_req_o        <= 1'b0;
      mem_we_o         <= 1'b0;
      mem_addr_o       <= 32'h0000_0000;
      mem_wdata_o      <= 32'h0000_0000;
      mem_be_o         <= 4'h0;
    end else begin
      ld <= 1'b0;
      unique case (state)
        tx_list_pkg::ST_IDLE: begin
          if (start_i) begin
            list_base        <= {list_addr_i[31:tx_list_pkg::LINK_IGNORE],
                                 3'h0};
            mem_addr_o       <= {list_addr_i[31:tx_list_pkg::LINK_IGNORE],
                                 3'h0};
            widx             <= 5'h0;
            mem_req_o        <= 1'b1;
            mem_we_o         <= 1'b0;
            mem_be_o         <= 4'hf;
            channel_active_o <= 1'b1;
            adapter_check_o  <= 1'b0;
            state            <= tx_list_pkg::ST_DESC;
          end
        end
        tx_list_pkg::ST_DESC: begin
          // whole list, link included, in one burst
          if (mem_ack_i) begin
            if (widx == tx_list_pkg::DESC_LAST) begin
              mem_req_o <= 1'b0;
              state     <= tx_list_pkg::ST_CHECK;
            end else begin
              widx       <= widx + 5'h1;
              mem_addr_o <= mem_addr_o + tx_list_pkg::WORD_STEP;
            end
          end
        end
        tx_list_pkg::ST_CHECK: begin
          if (frag_sum != {19'h0, frame_size}) begin
            adapter_check_o  <= 1'b1;
            channel_active_o <= 1'b0;
            state            <= tx_list_pkg::ST_IDLE;
          end else begin
            frag  <= 4'h0;
            state <= tx_list_pkg::ST_FRAG;
          end
        end
        tx_list_pkg::ST_FRAG: begin
          if (frag == nfrag) begin
            // status once all bytes are handed to the FIFO
            // only the status half-word is written
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_be_o    <= tx_list_pkg::STAT_BE;
            mem_addr_o  <= list_base + tx_list_pkg::STAT_OFS;
            // end-of-channel bit set on the final list
            mem_wdata_o <= {16'h0, req_stat
                            | (16'h1 << tx_list_pkg::FRM_CMP_BIT)
                            | ((desc[0] == 32'h0)
                               ? (16'h1 << tx_list_pkg::EOC_BIT) : 16'h0)};
            state       <= tx_list_pkg::ST_STAT;
          end else begin
            cur_addr <= desc[3 + 2*frag];
            rem      <= desc[2 + 2*frag][30:0];
            if (desc[2 + 2*frag][30:0] == 31'h0) begin
              frag <= frag + 4'h1;
            end else begin
              state <= tx_list_pkg::ST_RDREQ;
            end
          end
        end
        tx_list_pkg::ST_RDREQ: begin
          mem_req_o  <= 1'b1;
          mem_we_o   <= 1'b0;
          mem_be_o   <= 4'hf;
          mem_addr_o <= {cur_addr[31:2], 2'h0};
          state      <= tx_list_pkg::ST_DREAD;
        end
        tx_list_pkg::ST_DREAD: begin
          if (mem_ack_i) begin
            mem_req_o <= 1'b0;
            ld        <= 1'b1;
            cur_addr  <= cur_addr + {29'h0, nbytes};
            rem       <= rem - {28'h0, nbytes};
            state     <= tx_list_pkg::ST_UNPK;
          end
        end
        tx_list_pkg::ST_UNPK: begin
          if (!ld && !busy) begin
            if (rem == 31'h0) begin
              frag  <= frag + 4'h1;
              state <= tx_list_pkg::ST_FRAG;
            end else begin
              state <= tx_list_pkg::ST_RDREQ;
            end
          end
        end
        tx_list_pkg::ST_STAT: begin
          if (mem_ack_i) begin
            mem_we_o <= 1'b0;
            // halt after the final status write
            if (desc[0] == 32'h0) begin
              mem_req_o        <= 1'b0;
              channel_active_o <= 1'b0;
              state            <= tx_list_pkg::ST_IDLE;
            end else begin
              // next list on an eight-byte boundary
              list_base  <= {desc[0][31:tx_list_pkg::LINK_IGNORE], 3'h0};
              mem_addr_o <= {desc[0][31:tx_list_pkg::LINK_IGNORE], 3'h0};
              mem_be_o   <= 4'hf;
              widx       <= 5'h0;
              state      <= tx_list_pkg::ST_DESC;
            end
          end
        end
      endcase
    end
  end

  // descriptor words captured during the burst
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int k = 0; k < tx_list_pkg::DESC_WORDS; k++) begin
        desc[k] <= 32'h0000_0000;
      end
    end else if (state == tx_list_pkg::ST_DESC && mem_ack_i) begin
      desc[widx] <= mem_rdata_i;
    end
  end

  // pending end-of-frame count; a new frame and an ack together cancel
  assign eof_inc = (state == tx_list_pkg::ST_STAT) && mem_ack_i;
  assign eof_dec = eof_ack_i && (eof_cnt != 8'h0);
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      eof_cnt <= 8'h0;
    end else if (eof_inc && !eof_dec &&
                 eof_cnt != tx_list_pkg::EOF_CNT_MAX) begin
      eof_cnt <= eof_cnt + 8'h1;
    end else if (eof_dec && !eof_inc) begin
      eof_cnt <= eof_cnt - 8'h1;
    end
  end

  // end-of-channel set on halt after the final status write, set wins over ack
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      eoc_flag <= 1'b0;
    end else if (state == tx_list_pkg::ST_STAT && mem_ack_i &&
                 desc[0] == 32'h0) begin
      eoc_flag <= 1'b1;
    end else if (eoc_ack_i) begin
      eoc_flag <= 1'b0;
    end
  end

  // end-of-channel shown only with no end-of-frame pending
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      eof_event_o <= 1'b0;
      eoc_event_o <= 1'b0;
    end else begin
      eof_event_o <= (eof_cnt != 8'h0);
      eoc_event_o <= eoc_flag && (eof_cnt == 8'h0);
    end
  end

  word_unpacker u_unpack (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .load_i    (ld),
    .word_i    (mem_rdata_q),
    .lane_i    (lane_q),
    .count_i   (count_q),
    .last_i    (last_q),
    .meta_i    (meta),
    .busy_o    (busy),
    .out       (bytes_if.src)
  );

  // word and slicing held from the acknowledge cycle for the load pulse
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mem_rdata_q <= 32'h0000_0000;
      lane_q      <= 2'h0;
      count_q     <= 3'h0;
      last_q      <= 1'b0;
    end else if (state == tx_list_pkg::ST_DREAD && mem_ack_i) begin
      mem_rdata_q <= mem_rdata_i;
      lane_q      <= lane;
      count_q     <= nbytes;
      last_q      <= is_last_word;
    end
  end

  tx_fifo #(
    .WIDTH (tx_list_pkg::STREAM_W),
    .DEPTH (tx_list_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .in          (bytes_if.snk),
    .out_data_o  (fifo_out),
    .out_valid_o (tx_valid_o),
    .out_ready_i (tx_ready_i)
  );

  assign tx_data_o  = fifo_out[7:0];
  assign tx_last_o  = fifo_out[8];
  assign pass_fcs_o = fifo_out[9];
  assign tx_prio_o  = fifo_out[12:10];
endmodule : tx_list_fetch_engine

//--- tb/host_mem_model.sv
// host memory model answering the engine's memory port
// assumes requests stand until acknowledged
`timescale 1ns/1ns
module host_mem_model (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  // answer speed
  input  wire logic        slow_i,
  // memory port
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  input  wire logic [3:0]  mem_be_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [31:0] mem [256];
  logic [1:0]  waited;
  logic [7:0]  tick;

  assign mem_ack_o = mem_req_i && waited == (slow_i ? 2'h2 : 2'h0);
  // data lines carry noise outside an answer
  assign mem_rdata_o = mem_ack_o ? mem[mem_addr_i[9:2]] : {4{tick}};

  always @(posedge ref_clk_i) begin
    tick <= reset_i ? 8'h00 : tick + 8'h3b;
    if (reset_i || mem_ack_o)
      waited <= 2'h0;
    else if (mem_req_i)
      waited <= waited + 2'h1;
  end

  // written status lands on enabled bytes only
  always @(posedge ref_clk_i) begin
    for (int b = 0; b < 4; b++) begin
      if (mem_ack_o && mem_we_i && mem_be_i[b])
        mem[mem_addr_i[9:2]][8 * b +: 8] <= mem_wdata_i[8 * b +: 8];
    end
  end
endmodule : host_mem_model

//--- tb/tx_list_fetch_engine_asserts.sv
// port checker for the transmit list fetch engine
// assumes it is bound to the engine's top module
`timescale 1ns/1ns
module tx_list_fetch_engine_asserts (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic [1:0]  net_protocol_i,
  input wire logic        channel_active_o,
  input wire logic        adapter_check_o,
  input wire logic        eof_event_o,
  input wire logic        eoc_event_o,
  input wire logic        mem_req_o,
  input wire logic        mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic [31:0] mem_wdata_o,
  input wire logic [3:0]  mem_be_o,
  input wire logic        mem_ack_i,
  input wire logic        tx_valid_o,
  input wire logic        tx_ready_i,
  input wire logic        tx_last_o,
  input wire logic [2:0]  tx_prio_o
);
  logic wr_done;
  assign wr_done = mem_req_o && mem_we_o && mem_ack_i;
  default clocking dc @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  AST_REQ_STANDS: assert property (
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)
      && $stable(mem_we_o) && $stable(mem_wdata_o))
    else $error("memory request changed before acknowledge");
  AST_LINK_UNTOUCHED: assert property (
    mem_req_o && mem_we_o |-> mem_addr_o[2:0] == 3'h4
      && mem_be_o == tx_list_pkg::STAT_BE)
    else $error("write outside the status half word");
  AST_DONE_FLAG: assert property (
    mem_req_o && mem_we_o |-> mem_wdata_o[tx_list_pkg::FRM_CMP_BIT])
    else $error("status written without frame done");
  AST_EOC_AFTER_EOF: assert property (
    eoc_event_o |-> !eof_event_o)
    else $error("end of channel shown with end of frame pending");
  AST_EOF_AFTER_WRITE: assert property (
    $rose(eof_event_o) |-> $past(wr_done, 2))
    else $error("end of frame without status write");
  AST_CHECK_HALTS: assert property (
    $rose(adapter_check_o) |-> ##[0:2] !channel_active_o)
    else $error("channel runs on after adapter check");
  AST_PRIO_MASKED: assert property (
    tx_valid_o && !net_protocol_i[1] |-> tx_prio_o == 3'h0)
    else $error("priority passed for plain protocol");
  AST_HALT_QUIET: assert property (
    !channel_active_o |-> !mem_req_o)
    else $error("memory access while channel halted");

  cover property ($rose(eoc_event_o));
  cover property ($rose(adapter_check_o));
  cover property (tx_valid_o && tx_ready_i && tx_last_o);
endmodule : tx_list_fetch_engine_asserts

bind tx_list_fetch_engine tx_list_fetch_engine_asserts chk (
  .ref_clk_i, .reset_i, .net_protocol_i, .channel_active_o,
  .adapter_check_o, .eof_event_o, .eoc_event_o, .mem_req_o, .mem_we_o,
  .mem_addr_o, .mem_wdata_o, .mem_be_o, .mem_ack_i, .tx_valid_o,
  .tx_ready_i, .tx_last_o, .tx_prio_o
);

//--- tb/tb_top.sv
// self-checking bench for the transmit list fetch engine
// assumes the host memory model sits on the memory port
`timescale 1ns/1ns
module tb_top;
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        start_i = 1'b0;
  logic [31:0] list_addr_i = 32'h0;
  logic [1:0]  net_protocol_i = 2'h0;
  logic        eof_ack_i = 1'b0;
  logic        eoc_ack_i = 1'b0;
  logic        tx_ready_i = 1'b0;
  logic        slow = 1'b0;
  logic        channel_active_o, adapter_check_o, eof_event_o, eoc_event_o;
  logic        mem_req_o, mem_we_o, mem_ack_i, tx_last_o, pass_fcs_o;
  logic        tx_valid_o;
  logic [31:0] mem_addr_o, mem_wdata_o, mem_rdata_i;
  logic [3:0]  mem_be_o;
  logic [7:0]  tx_data_o;
  logic [2:0]  tx_prio_o;
  logic [12:0] got;
  logic [12:0] exq[$];
  int          err_count = 0;
  int          n_compared = 0;
  int          cyc = 0;

  tx_list_fetch_engine DUT (
    .ref_clk_i, .reset_i, .start_i, .list_addr_i, .net_protocol_i,
    .channel_active_o, .adapter_check_o, .eof_ack_i, .eoc_ack_i,
    .eof_event_o, .eoc_event_o, .mem_req_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_be_o, .mem_ack_i, .mem_rdata_i, .tx_data_o,
    .tx_last_o, .pass_fcs_o, .tx_prio_o, .tx_valid_o, .tx_ready_i
  );
  host_mem_model MEM (
    .ref_clk_i, .reset_i, .slow_i(slow), .mem_req_i(mem_req_o),
    .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_be_i(mem_be_o),
    .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i)
  );

  initial forever #25 ref_clk_i = ~ref_clk_i;

  function automatic logic [7:0] pat(input int a);
    return a[7:0] ^ 8'h5a;
  endfunction : pat

  task automatic check(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : step

  // link and request word go in as whole words
  task automatic head(input logic [31:0] b, l, input logic [15:0] sz, st);
    MEM.mem[b[9:2]] = l;
    MEM.mem[b[9:2] + 1] = {sz, st};
  endtask : head

  // bytes expected up to and including the last fragment
  task automatic pair(input logic [31:0] b, input int i,
                      input logic [31:0] c, input int a,
                      input logic [3:0] h, input bit push);
    MEM.mem[b[9:2] + 2 + 2 * i] = c;
    MEM.mem[b[9:2] + 3 + 2 * i] = a;
    for (int k = 0; push && k < c[15:0]; k++)
      exq.push_back({h, c[31] && k == c[15:0] - 1, pat(a + k)});
  endtask : pair

  task automatic run(input logic [31:0] a, input logic [1:0] p,
                     input logic s);
    @(posedge ref_clk_i);
    start_i <= 1'b1;
    list_addr_i <= a;
    net_protocol_i <= p;
    slow <= s;
    @(posedge ref_clk_i);
    start_i <= 1'b0;
    step(1);
    for (int i = 0; i < 3000 && channel_active_o === 1'b1; i++)
      step(1);
    if (channel_active_o !== 1'b0) begin
      err_count++;
      complete_run();
    end
  endtask : run

  task automatic ack(input bit eoc);
    @(posedge ref_clk_i);
    eof_ack_i <= !eoc;
    eoc_ack_i <= eoc;
    @(posedge ref_clk_i);
    eof_ack_i <= 1'b0;
    eoc_ack_i <= 1'b0;
    step(2);
  endtask : ack

  // consumer stalls early so the fifo fills, then takes three in four
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    tx_ready_i <= cyc > 150 && cyc % 4 != 3;
    if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
      got = {tx_prio_o, pass_fcs_o, tx_last_o, tx_data_o};
      if (exq.size() == 0)
        check("surplus byte", {19'h0, got}, 32'hffff_ffff);
      else
        check("frame byte", got, exq.pop_front());
    end
  end

  initial begin
    for (int a = 0; a < 1024; a++)
      MEM.mem[a >> 2][8 * (a % 4) +: 8] = pat(a);
    // two chained lists, first link has low bits set
    head(32'h000, 32'h63, 16'h000a, 16'h3205);
    pair(32'h000, 0, 32'h5, 32'h201, 4'hb, 1'b1);
    pair(32'h000, 1, 32'h2, 32'h20e, 4'hb, 1'b1);
    pair(32'h000, 2, 32'h8000_0003, 32'h233, 4'hb, 1'b1);
    pair(32'h000, 3, 32'h7, 32'h240, 4'hb, 1'b0);
    head(32'h060, 32'h0, 16'h000a, 16'h3003);
    for (int i = 0; i < 10; i++)
      pair(32'h060, i, {i == 9, 31'h1}, 32'h260 + 3 * i, 4'h6, 1'b1);
    repeat (12) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    run(32'h0, 2'h2, 1'b0);
    step(60);
    check("status 0", MEM.mem[1], 32'h000a_7205);
    check("link 0", MEM.mem[0], 32'h63);
    check("status 1", MEM.mem[25], 32'h000a_7803);
    check("eof", eof_event_o, 1'b1);
    check("eoc held", eoc_event_o, 1'b0);
    ack(1'b0);
    check("eof second", eof_event_o, 1'b1);
    ack(1'b0);
    check("eof done", eof_event_o, 1'b0);
    check("eoc shown", eoc_event_o, 1'b1);
    ack(1'b1);
    check("eoc cleared", eoc_event_o, 1'b0);
    // frame size one over the fragment total, slow memory
    head(32'h0c0, 32'h0, 16'h0009, 16'h3000);
    pair(32'h0c0, 0, 32'h8000_0008, 32'h300, 4'h0, 1'b0);
    run(32'h0c0, 2'h2, 1'b1);
    step(20);
    check("adapter check", adapter_check_o, 1'b1);
    check("status kept", MEM.mem[49], 32'h0009_3000);
    check("no eof", eof_event_o, 1'b0);
    // plain protocol, zero count after the last fragment
    head(32'h120, 32'h0, 16'h0004, 16'h3007);
    pair(32'h120, 0, 32'h8000_0004, 32'h301, 4'h0, 1'b1);
    pair(32'h120, 1, 32'h0, 32'h3f0, 4'h0, 1'b0);
    run(32'h120, 2'h1, 1'b1);
    step(40);
    check("check cleared", adapter_check_o, 1'b0);
    check("status 2", MEM.mem[73], 32'h0004_7807);
    // second priority protocol, supplied check sequence, start lane two
    head(32'h180, 32'h0, 16'h0002, 16'h3206);
    pair(32'h180, 0, 32'h8000_0002, 32'h302, 4'hd, 1'b1);
    run(32'h180, 2'h3, 1'b0);
    step(30);
    check("status 3", MEM.mem[97], 32'h0002_7a06);
    check("bytes left", exq.size(), 0);
    complete_run();
  end
endmodule : tb_top
